/* hw/ncc_cpu_end.sv */
// CPU-side sleep controller with APB registers, interrupts and pin hold.
// How it works
// - Sleep conversion only in idle or noise mode.
// - Software readies converter before noise sleep.
// - Conversion starts once the CPU clock halts.
// - Completion raises interrupt that wakes the CPU.
// - Other wake-up still gets the completion request.
// - After waking stay active until next sleep.
// - Other sleep modes leave the converter powered.
// - Software should disable converter before deep sleep.
// - Re-enabling converter makes next conversion extended.
// - Discard first result after reference change.
// - Digital port outputs frozen during conversions.
`timescale 1ns/1ps
`default_nettype none
module ncc_cpu_end
   import ncc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        ce_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        irq_in,
   output logic             irq_out,
   output logic      [7:0]  pins_out,
   output logic      [1:0]  ref_sel_out,
   ncc_link_if.host         lnk
);
   typedef enum logic [1:0] {NCC_ACTIVE, NCC_HALTING, NCC_ASLEEP} ncc_slp_e;

   ncc_slp_e            state;
   ncc_slp_e            next_state;
   logic                en_q;
   logic                single_q;
   logic [MODE_W-1:0]   mode_q;
   logic [NIRQ-1:0]     mask_q;
   logic [NIRQ-1:0]     istat;
   logic [NIRQ-1:0]     ist_set;
   logic [NIRQ-1:0]     ist_clr;
   logic [PIN_W-1:0]    pins_req;
   logic                halted_q;
   logic                start_q;
   logic                ack_q;
   logic                req_q;
   logic                ref_dirty;
   logic                suspect;
   logic                deep_en;
   logic                fire;
   logic                wr;
   logic                slp_cmd;
   logic                wake;
   logic                precond;
   logic                done_rise;
   logic                ref_chg;
   logic                hit;
   logic [31:0]         rd_val;

   assign lnk.sleep_mode  = mode_q;
   assign lnk.cpu_halted  = halted_q;
   assign lnk.conv_enable = en_q;
   assign lnk.single_mode = single_q;
   assign lnk.start_req   = start_q;
   assign lnk.done_ack    = ack_q;

   always_comb
   begin
      fire      = psel_in & penable_in & pready_out;
      wr        = fire & pwrite_in;
      slp_cmd   = wr & (paddr_in == OFS_CMD) & pwdata_in[CMD_SLEEP];
      wake      = |(istat & mask_q);
      done_rise = lnk.done_req & ~req_q;
      ref_chg   = wr & (paddr_in == OFS_REF) & (pwdata_in[REF_W-1:0] != ref_sel_out);
      precond   = en_q & single_q & mask_q[IRQ_CONV] & ~lnk.conv_busy;
      ist_set   = '0;
      ist_set[IRQ_CONV] = done_rise;
      ist_set[IRQ_EXT]  = irq_in;
      ist_clr   = (wr & (paddr_in == OFS_ISTAT)) ? pwdata_in[NIRQ-1:0] : '0;
   end

   always_comb
   begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr_in)
         OFS_CTRL:
         begin
            rd_val[CTRL_EN]     = en_q;
            rd_val[CTRL_SINGLE] = single_q;
            rd_val[CTRL_MODE +: MODE_W] = mode_q;
         end
         OFS_CMD:   rd_val = 32'h0000_0000;
         OFS_STAT:
         begin
            rd_val[ST_ASLEEP]  = halted_q;
            rd_val[ST_BUSY]    = lnk.conv_busy;
            rd_val[ST_READY]   = precond;
            rd_val[ST_SUSPECT] = suspect;
            rd_val[ST_DEEP_EN] = deep_en;
         end
         OFS_ISTAT: rd_val[NIRQ-1:0]  = istat;
         OFS_IMASK: rd_val[NIRQ-1:0]  = mask_q;
         OFS_PINS:  rd_val[PIN_W-1:0] = pins_req;
         OFS_REF:   rd_val[REF_W-1:0] = ref_sel_out;
         default:   hit = 1'b0;
      endcase
   end

   // One wait state: the slave answers in the second access cycle.
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         pslverr_out <= psel_in & penable_in & ~pready_out & ~hit;
         prdata_out  <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ? rd_val : 32'h0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         en_q        <= 1'b0;
         single_q    <= 1'b0;
         mode_q      <= MODE_RST;
         mask_q      <= MASK_RST;
         pins_req    <= PINS_RST;
         ref_sel_out <= REF_RST;
      end
      else if (ce_in && wr)
      begin
         case (paddr_in)
            OFS_CTRL:
            begin
               en_q     <= pwdata_in[CTRL_EN];
               single_q <= pwdata_in[CTRL_SINGLE];
               mode_q   <= pwdata_in[CTRL_MODE +: MODE_W];
            end
            OFS_IMASK: mask_q      <= pwdata_in[NIRQ-1:0];
            OFS_PINS:  pins_req    <= pwdata_in[PIN_W-1:0];
            OFS_REF:   ref_sel_out <= pwdata_in[REF_W-1:0];
            default:   mask_q      <= mask_q;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         start_q <= 1'b0;
         ack_q   <= 1'b0;
         req_q   <= 1'b0;
         irq_out <= 1'b0;
      end
      else if (ce_in)
      begin
         start_q <= wr & (paddr_in == OFS_CMD) & pwdata_in[CMD_START];
         ack_q   <= wr & (paddr_in == OFS_ISTAT) & pwdata_in[IRQ_CONV];
         req_q   <= lnk.done_req;
         irq_out <= wake;
      end
   end

   // other interrupts set their own bit
   ncc_sticky #(.W (NIRQ)) u_istat (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .ce_in   (ce_in),
      .set_in  (ist_set),
      .clr_in  (ist_clr),
      .q_out   (istat)
   );

   always_comb
   begin
      next_state = state;
      case (state)
         NCC_ACTIVE:
         begin
            if (slp_cmd)
            begin
               next_state = NCC_HALTING;
            end
         end
         NCC_HALTING: next_state = NCC_ASLEEP;
         NCC_ASLEEP:
         begin
            if (wake)
            begin
               next_state = NCC_ACTIVE;
            end
         end
         default:     next_state = NCC_ACTIVE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state    <= NCC_ACTIVE;
         halted_q <= 1'b0;
         deep_en  <= 1'b0;
      end
      else if (ce_in)
      begin
         state    <= next_state;
         halted_q <= (next_state == NCC_ASLEEP);
         if (slp_cmd)
         begin
            deep_en <= en_q & ~ncc_nc_mode(mode_q);
         end
      end
   end

   // mark result after reference change
   // A change in the same cycle as a completion still marks the next result.
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ref_dirty <= 1'b0;
         suspect   <= 1'b0;
      end
      else if (ce_in)
      begin
         if (done_rise)
         begin
            suspect   <= ref_dirty;
            ref_dirty <= ref_chg;
         end
         else if (ref_chg)
         begin
            ref_dirty <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pins_out <= PINS_RST;
      end
      else if (ce_in && !lnk.conv_busy)
      begin
         pins_out <= pins_req;
      end
   end
endmodule
`default_nettype wire

/* hw/ncc_pkg.sv */
// Shared constants for the sleep-time conversion controller.
package ncc_pkg;
   // Register byte offsets of the CPU-side controller.
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CMD   = 8'h04;
   localparam logic [7:0] OFS_STAT  = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0c;
   localparam logic [7:0] OFS_IMASK = 8'h10;
   localparam logic [7:0] OFS_PINS  = 8'h14;
   localparam logic [7:0] OFS_REF   = 8'h18;
   // Field positions.
   localparam int CTRL_EN     = 0;
   localparam int CTRL_SINGLE = 1;
   localparam int CTRL_MODE   = 4;
   localparam int CMD_SLEEP   = 0;
   localparam int CMD_START   = 1;
   localparam int ST_ASLEEP   = 0;
   localparam int ST_BUSY     = 1;
   localparam int ST_READY    = 2;
   localparam int ST_SUSPECT  = 3;
   localparam int ST_DEEP_EN  = 4;
   localparam int IRQ_CONV    = 0;
   localparam int IRQ_EXT     = 1;
   // Widths.
   localparam int NIRQ  = 2;
   localparam int PIN_W = 8;
   localparam int REF_W = 2;
   localparam int MODE_W = 3;
   // Sleep mode codes.
   localparam logic [2:0] SLP_IDLE  = 3'h0;
   localparam logic [2:0] SLP_NOISE = 3'h1;
   localparam logic [2:0] SLP_PSAVE = 3'h2;
   localparam logic [2:0] SLP_PDOWN = 3'h3;
   localparam logic [2:0] SLP_STBY  = 3'h4;
   localparam logic [2:0] SLP_XSTBY = 3'h5;
   // Reset values.
   localparam logic [2:0]  MODE_RST = 3'h0;
   localparam logic [1:0]  MASK_RST = 2'h0;
   localparam logic [7:0]  PINS_RST = 8'h00;
   localparam logic [1:0]  REF_RST  = 2'h0;

   // True for the two modes in which a sleep-time conversion may run.
   function automatic logic ncc_nc_mode(input logic [2:0] mode);
      return (mode == SLP_IDLE) || (mode == SLP_NOISE);
   endfunction
endpackage

/* hw/ncc_link_if.sv */
// Link between the CPU sleep controller and the converter control end.
`timescale 1ns/1ps
`default_nettype none
interface ncc_link_if;
   logic [2:0] sleep_mode;
   logic       cpu_halted;
   logic       conv_enable;
   logic       single_mode;
   logic       start_req;
   logic       done_ack;
   logic       conv_busy;
   logic       done_req;

   modport dev (
      input  sleep_mode,
      input  cpu_halted,
      input  conv_enable,
      input  single_mode,
      input  start_req,
      input  done_ack,
      output conv_busy,
      output done_req
   );
   modport host (
      output sleep_mode,
      output cpu_halted,
      output conv_enable,
      output single_mode,
      output start_req,
      output done_ack,
      input  conv_busy,
      input  done_req
   );
endinterface
`default_nettype wire

/* hw/ncc_sticky.sv */
// Sticky event bits, cleared by write-one, where a set beats a clear.
`timescale 1ns/1ps
`default_nettype none
module ncc_sticky #(
   parameter int W = 2
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   output logic      [W-1:0] q_out
);
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         q_out <= '0;
      end
      else if (ce_in)
      begin
         q_out <= set_in | (q_out & ~clr_in);
      end
   end
endmodule
`default_nettype wire

/* hw/ncc_conv_end.sv */
// Converter-side control: sleep-triggered start, completion flag, extended first conversion.
`timescale 1ns/1ps
`default_nettype none
module ncc_conv_end
   import ncc_pkg::*;
(
   input  wire logic  clk_in,
   input  wire logic  rstn_in,
   input  wire logic  ce_in,
   ncc_link_if.dev    lnk,
   input  wire logic  seq_done_in,
   output logic       seq_start_out,
   output logic       seq_ext_out,
   output logic       conv_power_out
);
   logic halt_q;
   logic first_pend;
   logic busy;
   logic done_flag;
   logic sleep_trig;
   logic restart;
   logic start_go;

   assign lnk.conv_busy = busy;
   assign lnk.done_req  = done_flag;

   always_comb
   begin
      sleep_trig = lnk.cpu_halted & ~halt_q & ncc_nc_mode(lnk.sleep_mode);
      restart    = busy & seq_done_in & ~lnk.single_mode;
      start_go   = lnk.conv_enable & ((~busy & (lnk.start_req | sleep_trig)) | restart);
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         halt_q <= 1'b0;
      end
      else if (ce_in)
      begin
         halt_q <= lnk.cpu_halted;
      end
   end

   // Disabling aborts the running conversion; its result is never flagged.
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy <= 1'b0;
      end
      else if (ce_in)
      begin
         if (!lnk.conv_enable)
         begin
            busy <= 1'b0;
         end
         else if (start_go)
         begin
            busy <= 1'b1;
         end
         else if (seq_done_in)
         begin
            busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         first_pend <= 1'b1;
      end
      else if (ce_in)
      begin
         if (!lnk.conv_enable)
         begin
            first_pend <= 1'b1;
         end
         else if (start_go)
         begin
            first_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         seq_start_out <= 1'b0;
         seq_ext_out   <= 1'b0;
      end
      else if (ce_in)
      begin
         seq_start_out <= start_go;
         seq_ext_out   <= start_go & first_pend;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         conv_power_out <= 1'b0;
      end
      else if (ce_in)
      begin
         conv_power_out <= lnk.conv_enable;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         done_flag <= 1'b0;
      end
      else if (ce_in)
      begin
         if (busy & seq_done_in & lnk.conv_enable)
         begin
            done_flag <= 1'b1;
         end
         else if (lnk.done_ack)
         begin
            done_flag <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/ncc_link_monitor.sv */
// Concurrent checks on the link between the two controller ends.
`timescale 1ns/1ps
`default_nettype none
module ncc_link_monitor (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic [2:0] sleep_mode,
   input  wire logic       cpu_halted,
   input  wire logic       conv_enable,
   input  wire logic       single_mode,
   input  wire logic       start_req,
   input  wire logic       done_ack,
   input  wire logic       conv_busy,
   input  wire logic       done_req
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   chk_sleep_start: assert property (
      $rose(cpu_halted) && sleep_mode <= 3'h1 && conv_enable && !conv_busy
      |-> ##[1:2] conv_busy) else $error("no conversion after halt");
   chk_deep_idle: assert property (
      $rose(cpu_halted) && sleep_mode > 3'h1 && !conv_busy && !start_req
      |=> !conv_busy [*2]) else $error("conversion in deep sleep");
   chk_done_hold: assert property (
      done_req && !done_ack && conv_enable |=> done_req)
      else $error("completion flag lost");
   chk_stay_awake: assert property (
      $fell(cpu_halted) |-> !cpu_halted [*3]) else $error("fell asleep again");
   chk_off_idle: assert property (
      !conv_enable |=> !conv_busy) else $error("busy while disabled");
   chk_single_end: assert property (
      $rose(done_req) && single_mode |-> !conv_busy) else $error("single did not stop");
   chk_done_cause: assert property (
      $rose(done_req) |-> $past(conv_busy)) else $error("completion without conversion");
   chk_ack_clear: assert property (
      done_ack && !conv_busy |=> !done_req) else $error("ack did not clear");

   cover property ($rose(done_req));
   cover property ($fell(cpu_halted));
   cover property ($rose(cpu_halted) && sleep_mode > 3'h1);
endmodule
`default_nettype wire

/* verif/tb_adc_sleep_noise_canceler_ctrl.sv */
// Testbench joining both ends of the sleep-time conversion controller.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sleep_noise_canceler_ctrl
   import ncc_pkg::*;
;
   logic        clk_in, rstn_in, psel, pen, pwr, irq_in, sdone, ce;
   logic        pready, perr, irq, sstart, sext, cpwr, last_ext;
   logic [7:0]  paddr, pins;
   logic [1:0]  refs;
   logic [31:0] pwdata, prdata;
   int          num_errors = 0, n_tests = 0, n_starts = 0;
   ncc_link_if  lnk ();

   ncc_cpu_end ncc_cpu_end_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .irq_in(irq_in), .irq_out(irq), .pins_out(pins), .ref_sel_out(refs), .lnk(lnk));
   ncc_conv_end ncc_conv_end_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
      .lnk(lnk), .seq_done_in(sdone), .seq_start_out(sstart), .seq_ext_out(sext),
      .conv_power_out(cpwr));
   ncc_link_monitor ncc_link_monitor_inst (.clk_in(clk_in), .rstn_in(rstn_in),
      .sleep_mode(lnk.sleep_mode), .cpu_halted(lnk.cpu_halted),
      .conv_enable(lnk.conv_enable), .single_mode(lnk.single_mode),
      .start_req(lnk.start_req), .done_ack(lnk.done_ack),
      .conv_busy(lnk.conv_busy), .done_req(lnk.done_req));

   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Starts are counted here so scenarios can see pulses they were not waiting on.
   always @(posedge clk_in)
   begin
      if (sstart === 1'b1)
      begin
         n_starts <= n_starts + 1;
         last_ext <= sext;
      end
   end

   task automatic complete_run();
      $display("errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_in);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      r = prdata;
      e = perr;
      if (i >= 20)
      begin
         chk1(1'b0, 1'b1);
         complete_run();
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask

   task automatic wait_halt(input logic lvl);
      int i;
      for (i = 0; i < 50 && lnk.cpu_halted !== lvl; i++)
         @(posedge clk_in);
      if (i >= 50)
      begin
         chk1(1'b0, 1'b1);
         complete_run();
      end
   endtask

   task automatic done_pulse();
      sdone <= 1'b1;
      @(posedge clk_in);
      sdone <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic irq_pulse();
      irq_in <= 1'b1;
      @(posedge clk_in);
      irq_in <= 1'b0;
   endtask

   task automatic s_regs();
      logic [31:0] r;
      logic        e;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_IMASK, 32'h0);
      rd(OFS_PINS, 32'h0);
      rd(OFS_REF, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      chk1(e, 1'b1);
   endtask

   task automatic s_sleep(input logic [2:0] m);
      int n;
      wr(OFS_IMASK, 32'h1);
      wr(OFS_CTRL, 32'h3 | ({29'h0, m} << CTRL_MODE));
      rd(OFS_STAT, 32'h1 << ST_READY);
      n = n_starts;
      wr(OFS_CMD, 32'h1);
      wait_halt(1'b1);
      repeat (3) @(posedge clk_in);
      chk(n_starts, n + 1);
      done_pulse();
      chk1(lnk.cpu_halted, 1'b0);
      chk1(irq, 1'b1);
      repeat (5) @(posedge clk_in);
      chk1(lnk.cpu_halted, 1'b0);
      rd(OFS_ISTAT, 32'h1);
      wr(OFS_ISTAT, 32'h1);
      repeat (2) @(posedge clk_in);
      chk1(irq, 1'b0);
      chk1(lnk.done_req, 1'b0);
   endtask

   task automatic s_other();
      wr(OFS_IMASK, 32'h3);
      wr(OFS_CTRL, 32'h3 | ({29'h0, SLP_NOISE} << CTRL_MODE));
      wr(OFS_CMD, 32'h1);
      wait_halt(1'b1);
      irq_pulse();
      wait_halt(1'b0);
      chk1(lnk.conv_busy, 1'b1);
      wr(OFS_ISTAT, 32'h2);
      done_pulse();
      chk1(lnk.done_req, 1'b1);
      rd(OFS_ISTAT, 32'h1);
      wr(OFS_ISTAT, 32'h1);
   endtask

   // Deep modes keep the converter on, so the wake-up comes from the other source.
   task automatic s_deep();
      int n;
      for (int m = 2; m <= 5; m++)
      begin
         n = n_starts;
         wr(OFS_CTRL, 32'h3 | (m << CTRL_MODE));
         wr(OFS_CMD, 32'h1);
         wait_halt(1'b1);
         repeat (6) @(posedge clk_in);
         chk(n_starts, n);
         chk1(cpwr, 1'b1);
         rd(OFS_STAT, (32'h1 << ST_ASLEEP) | (32'h1 << ST_READY) | (32'h1 << ST_DEEP_EN));
         irq_pulse();
         wait_halt(1'b0);
         wr(OFS_ISTAT, 32'h2);
      end
   endtask

   // Free running restarts on each completion; a held clock enable must swallow a pulse.
   task automatic s_free();
      int n;
      wr(OFS_CTRL, 32'h1);
      n = n_starts;
      wr(OFS_CMD, 32'h2);
      repeat (3) @(posedge clk_in);
      done_pulse();
      chk(n_starts, n + 2);
      chk1(lnk.done_req, 1'b1);
      ce <= 1'b0;
      sdone <= 1'b1;
      repeat (2) @(posedge clk_in);
      ce <= 1'b1;
      sdone <= 1'b0;
      @(posedge clk_in);
      chk(n_starts, n + 2);
      chk1(lnk.conv_busy, 1'b1);
      wr(OFS_ISTAT, 32'h1);
      wr(OFS_CTRL, 32'h0);
      @(posedge clk_in);
      chk1(lnk.conv_busy, 1'b0);
      chk1(cpwr, 1'b0);
      done_pulse();
      chk1(lnk.done_req, 1'b0);
   endtask

   task automatic s_ext();
      wr(OFS_CTRL, 32'h2);
      wr(OFS_REF, 32'h1);
      chk({30'h0, refs}, 32'h1);
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CMD, 32'h2);
      repeat (4) @(posedge clk_in);
      chk1(last_ext, 1'b1);
      wr(OFS_PINS, 32'ha5);
      repeat (2) @(posedge clk_in);
      chk({24'h0, pins}, 32'h0);
      done_pulse();
      chk({24'h0, pins}, 32'ha5);
      rd(OFS_STAT, (32'h1 << ST_READY) | (32'h1 << ST_SUSPECT) | (32'h1 << ST_DEEP_EN));
      wr(OFS_ISTAT, 32'h1);
      wr(OFS_CMD, 32'h2);
      repeat (4) @(posedge clk_in);
      chk1(last_ext, 1'b0);
      done_pulse();
      rd(OFS_STAT, (32'h1 << ST_READY) | (32'h1 << ST_DEEP_EN));
      wr(OFS_ISTAT, 32'h1);
   endtask

   initial
   begin
      rstn_in = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_in = 1'b0;
      ce = 1'b1;
      sdone = 1'b0;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      s_regs();
      s_sleep(SLP_IDLE);
      s_sleep(SLP_NOISE);
      s_other();
      s_deep();
      s_free();
      s_ext();
      complete_run();
   end
endmodule
`default_nettype wire
